//--- hdl/daf_pkg.sv
// constants shared by the flag logic unit and its register slave
package daf_pkg;
  // function codes
  localparam logic [4:0] OP_NOP = 5'h00;
  localparam logic [4:0] OP_ADDS = 5'h01;
  localparam logic [4:0] OP_ADD = 5'h02;
  localparam logic [4:0] OP_ADDC = 5'h03;
  localparam logic [4:0] OP_SUB = 5'h04;
  localparam logic [4:0] OP_SBC = 5'h05;
  localparam logic [4:0] OP_SUBR = 5'h06;
  localparam logic [4:0] OP_LSR = 5'h07;
  localparam logic [4:0] OP_SBCR = 5'h08;
  localparam logic [4:0] OP_LOAD_FLAGS = 5'h09;
  localparam logic [4:0] OP_CONJ_ADD = 5'h0a;
  localparam logic [4:0] OP_ARITH_LSH = 5'h0b;
  localparam logic [4:0] OP_XOR = 5'h0c;
  localparam logic [4:0] OP_OR = 5'h0d;
  localparam logic [4:0] OP_AND = 5'h0e;
  localparam logic [4:0] OP_ASR = 5'h0f;
  localparam logic [4:0] OP_REPEAT_EXEC_RELOAD = 5'h10;
  localparam logic [4:0] OP_REPEAT_EXEC = 5'h11;
  localparam logic [4:0] OP_REPEAT_LOAD = 5'h12;
  localparam logic [4:0] OP_CLR = 5'h13;
  localparam logic [4:0] OP_TRA_A = 5'h14;
  localparam logic [4:0] OP_TRA_B = 5'h15;
  localparam logic [4:0] OP_COM_A = 5'h16;
  localparam logic [4:0] OP_ROR = 5'h17;
  localparam logic [4:0] OP_COM_B = 5'h18;
  localparam logic [4:0] OP_LSLB = 5'h19;
  localparam logic [4:0] OP_LSRB = 5'h1a;
  localparam logic [4:0] OP_LSL = 5'h1b;
  localparam logic [4:0] OP_SET = 5'h1c;
  localparam logic [4:0] OP_SUBS = 5'h1d;
  // operating modes
  localparam logic [1:0] MODE_REAL = 2'h1;
  localparam logic [1:0] MODE_DOUBLE = 2'h2;
  localparam logic [1:0] MODE_CPLX = 2'h3;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_LEFT = 8'h04;
  localparam logic [7:0] OFS_RIGHT = 8'h08;
  localparam logic [7:0] OFS_CMD = 8'h0c;
  localparam logic [7:0] OFS_RESULT = 8'h10;
  localparam logic [7:0] OFS_FLAGS = 8'h14;
  localparam logic [7:0] OFS_TEST = 8'h18;
  localparam logic [7:0] OFS_REPEAT = 8'h1c;
  localparam logic [7:0] OFS_ACCESS = 8'h20;
  // field positions
  localparam int CTRL_CLAMP = 2;
  localparam int CMD_RPT_LSB = 8;
  localparam int TEST_SENSE = 4;
  localparam int TEST_TAKEN = 8;
  // flag_byte bit positions (flag_byte sits in bits 15:7 of the flags word)
  localparam int FB_SIGN_RE = 8;
  localparam int FB_SIGN_IM = 7;
  localparam int FB_CARRY_RE = 6;
  localparam int FB_CARRY_IM = 5;
  localparam int FB_ZERO = 4;
  localparam int FB_WRAP = 3;
  localparam int FB_STICKY = 2;
  localparam int FB_HALF = 1;
  localparam int FB_PROD = 0;
  // branch test codes
  localparam logic [3:0] TST_ALWAYS = 4'h0;
  localparam logic [3:0] TST_STICKY = 4'hb;
  // clamp values
  localparam logic [15:0] CLAMP_POS = 16'h7fff;
  localparam logic [15:0] CLAMP_NEG = 16'h8000;
  // bus answers and register reset values
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  localparam logic [6:0] ACCESS_RESET = 7'h00;
  localparam logic [1:0] MODE_RESET = 2'h1;
  typedef enum {REG_CTRL, REG_LEFT, REG_RIGHT, REG_CMD, REG_RESULT, REG_FLAGS,
                REG_TEST, REG_REPEAT, REG_ACCESS, REG_NONE} daf_reg_t;
endpackage

//--- hdl/daf_alu.sv
// combinational arithmetic lanes with per-lane carry, overflow and clamping
`timescale 1ns/10ps
module daf_alu
  import daf_pkg::*;
(
  input wire logic [4:0] op_i,
  input wire logic [1:0] mode_i,
  input wire logic clamp_i,
  input wire logic [31:0] left_i,
  input wire logic [31:0] right_i,
  input wire logic carry_real_i,
  input wire logic carry_imag_i,
  output logic [31:0] res_o,
  output logic sign_re_o,
  output logic sign_im_o,
  output logic carry_re_o,
  output logic carry_im_o,
  output logic z_o,
  output logic v_o,
  output logic hr_o
);
  import daf_pkg::*;

  // returns {carry, overflow, result}; dp selects a 32-bit lane
  function automatic logic [33:0] lane(input logic [4:0] op, input logic [31:0] a,
                                       input logic [31:0] b, input logic cin,
                                       input logic dp);
    logic [31:0] msk, x, y, r, sa;
    logic [32:0] s;
    logic ki, c, v, arith;
    int m;
    m = dp ? 31 : 15;
    msk = dp ? 32'hffffffff : 32'h0000ffff;
    // sign fill stays inside the lane, or it would leak into the carry bit
    sa = (a >> 4) | ((a[m] ? 32'hffffffff : 32'h0) & msk & ~(msk >> 4));
    x = a;
    y = b;
    ki = 1'b0;
    arith = 1'b1;
    case (op)
      OP_ADD: ;
      OP_ADDC: ki = cin;
      OP_ADDS: x = sa;
      OP_SUB: begin y = ~b & msk; ki = 1'b1; end
      OP_SBC: begin y = ~b & msk; ki = cin; end
      OP_SUBR: begin x = ~a & msk; ki = 1'b1; end
      OP_SBCR: begin x = ~a & msk; ki = cin; end
      OP_SUBS: begin x = ~sa & msk; ki = 1'b1; end
      default: arith = 1'b0;
    endcase
    s = {1'b0, x} + {1'b0, y} + {32'h0, ki};
    r = s[31:0] & msk;
    c = s[m + 1];
    v = (x[m] == y[m]) && (r[m] != x[m]);
    if (!arith) begin
      c = 1'b0;
      v = 1'b0;
      case (op)
        OP_AND: r = a & b;
        OP_OR: r = a | b;
        OP_XOR: r = a ^ b;
        OP_COM_A: r = ~a & msk;
        OP_COM_B: r = ~b & msk;
        OP_TRA_B: r = b;
        OP_CLR: r = 32'h0;
        OP_SET: r = msk;
        OP_ARITH_LSH: begin
          r = (a << 1) & msk;
          c = a[m];
          v = r[m] ^ r[m - 1];
        end
        OP_LSL: begin r = (a << 1) & msk; c = a[m]; end
        OP_LSLB: begin r = (a << 8) & msk; c = a[m - 7]; end
        OP_LSR: begin r = a >> 1; c = a[0]; end
        OP_LSRB: begin r = a >> 8; c = a[7]; end
        OP_ASR: begin r = a >> 1; r[m] = a[m]; c = a[0]; end
        OP_ROR: begin r = a >> 1; r[m] = cin; c = a[0]; end
        default: r = a;
      endcase
    end
    return {c, v, r};
  endfunction

  logic dp, cx, vr, vi;
  logic [33:0] lr, li;
  logic [15:0] rr, ri;
  logic [4:0] op_imag;

  assign dp = (mode_i == MODE_DOUBLE);
  assign cx = (mode_i == MODE_CPLX);
  // conjugate of the left input: imaginary lane subtracts it
  assign op_imag = (op_i == OP_CONJ_ADD) ? OP_SUBR : op_i;
  assign lr = dp ? lane(op_i == OP_CONJ_ADD ? OP_ADD : op_i, left_i, right_i, carry_real_i, 1'b1)
                 : lane(op_i == OP_CONJ_ADD ? OP_ADD : op_i, {16'h0, left_i[15:0]},
                        {16'h0, right_i[15:0]}, carry_real_i, 1'b0);
  assign li = lane(op_imag, {16'h0, left_i[31:16]}, {16'h0, right_i[31:16]}, carry_imag_i, 1'b0);
  assign vr = lr[32];
  assign vi = cx & li[32];
  // clamping does not apply in double precision
  assign rr = (clamp_i && vr) ? (lr[15] ? CLAMP_POS : CLAMP_NEG) : lr[15:0];
  assign ri = (clamp_i && vi) ? (li[15] ? CLAMP_POS : CLAMP_NEG) : li[15:0];
  assign res_o = dp ? lr[31:0] : (cx ? {ri, rr} : {16'h0, rr});
  assign sign_re_o = dp ? lr[31] : lr[15];
  assign sign_im_o = cx & li[15];
  assign carry_re_o = lr[33];
  assign carry_im_o = cx & li[33];
  assign z_o = dp ? (lr[31:0] == 32'h0) : (lr[15:0] == 16'h0) && (!cx || li[15:0] == 16'h0);
  assign v_o = vr | vi;
  assign hr_o = dp ? (lr[30] ^ lr[31]) : (lr[14] ^ lr[15]) | (cx & (li[14] ^ li[15]));
endmodule // daf_alu

//--- hdl/daf_flag_unit.sv
// function decode, flag generation and branch test with an AXI4-Lite register slave
// How it works
// - code 01010 adds right to conjugated left
// - code 10000 executes stored repeat, loads new
// - A is left input, B right input
// - shift-left overflow is bit14 xor bit15, bit30 xor bit31 in double
// - real sign follows real-part msb before clamping
// - imaginary sign follows imaginary msb before clamping, complex only
// - real carry is carry out of msb
// - imaginary carry out of imaginary msb
// - zero needs both parts zero in complex
// - overflow when unrepresentable, either part counts
// - sticky overflow cleared by the sticky branch test (code 1011), and loaded from left bit 9 by load-flags
// - half-range flag is bit14 xor bit15, bit30 xor bit31 in double
// - half-range flag latched, cleared by load-flags
// - product overflow latched, cleared by load-flags
// - clamping forces 7fff or 8000, not double
// - mode 01 real, 10 double, 11 complex
`timescale 1ns/10ps
module daf_flag_unit
  import daf_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
  input wire logic [2:0] S_AXI_AWPROT_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
  input wire logic [2:0] S_AXI_ARPROT_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  input wire logic [7:0] EXT_COND_I,
  input wire logic MUL_OVF_I,
  output logic [15:0] FLAGS_O,
  output logic [31:0] RESULT_O,
  output logic BRANCH_TAKEN_O
);
  import daf_pkg::*;

  typedef struct packed {
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [1:0] mode;
    logic clamp;
    logic [6:0] access_mode;
    logic [31:0] left;
    logic [31:0] right;
    logic [31:0] result;
    logic [8:0] flag_byte;
    logic [4:0] rpt;
    logic [4:0] test;
    logic taken;
  } daf_state_t;

  daf_state_t s, next_s;

  function automatic daf_reg_t decode(input logic [ADDR_W-1:0] a);
    case (8'(a))
      OFS_CTRL: return REG_CTRL;
      OFS_LEFT: return REG_LEFT;
      OFS_RIGHT: return REG_RIGHT;
      OFS_CMD: return REG_CMD;
      OFS_RESULT: return REG_RESULT;
      OFS_FLAGS: return REG_FLAGS;
      OFS_TEST: return REG_TEST;
      OFS_REPEAT: return REG_REPEAT;
      OFS_ACCESS: return REG_ACCESS;
      default: return REG_NONE;
    endcase
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction

  // ops that leave result and the ALU flag update alone when executed
  function automatic logic updates(input logic [4:0] op);
    return !(op inside {OP_NOP, OP_REPEAT_LOAD, OP_REPEAT_EXEC, OP_REPEAT_EXEC_RELOAD,
                        OP_LOAD_FLAGS});
  endfunction

  // ext: 0..3 event inputs, 4..6 status inputs, 7 ready input
  function automatic logic cond_sel(input logic [3:0] code, input logic [8:0] f,
                                    input logic [7:0] ext);
    case (code)
      4'h0: return 1'b1;
      4'h4: return ext[0];
      4'h2: return ext[1];
      4'h3: return ext[2];
      4'h1: return ext[3];
      4'hc: return ext[4];
      4'hd: return ext[5];
      4'he: return ext[6];
      4'hf: return ext[7];
      4'ha: return f[FB_CARRY_IM];
      4'h6: return f[FB_CARRY_RE];
      4'hb: return f[FB_STICKY];
      4'h7: return f[FB_WRAP];
      4'h9: return f[FB_SIGN_IM];
      4'h5: return f[FB_SIGN_RE];
      4'h8: return f[FB_ZERO];
      default: return 1'b0;
    endcase
  endfunction

  logic wr_go, rd_go, cmd_wr, exec, tst_wr, tst_cond;
  logic [4:0] func, eff_op;
  logic [31:0] alu_res;
  logic a_sign_re, a_sign_im, a_carry_re, a_carry_im, a_z, a_v, a_hr;
  logic [15:0] flags_word;
  daf_reg_t wsel, rsel;

  // both halves of a write are taken in the same cycle, so neither can be stranded
  assign wr_go = S_AXI_AWVALID_I && S_AXI_WVALID_I && !s.bvalid;
  assign rd_go = S_AXI_ARVALID_I && !s.rvalid;
  assign S_AXI_AWREADY_O = wr_go;
  assign S_AXI_WREADY_O = wr_go;
  assign S_AXI_ARREADY_O = !s.rvalid;
  assign wsel = decode(S_AXI_AWADDR_I);
  assign rsel = decode(S_AXI_ARADDR_I);
  assign func = S_AXI_WDATA_I[4:0];
  assign cmd_wr = wr_go && wsel == REG_CMD && S_AXI_WSTRB_I[0];
  assign tst_wr = wr_go && wsel == REG_TEST && S_AXI_WSTRB_I[0];
  // repeat execution substitutes the stored code
  assign eff_op = (func == OP_REPEAT_EXEC || func == OP_REPEAT_EXEC_RELOAD) ? s.rpt : func;
  assign exec = cmd_wr && updates(eff_op);
  assign tst_cond = cond_sel(S_AXI_WDATA_I[3:0], s.flag_byte, EXT_COND_I);
  // fifo-empty and circular bits belong elsewhere and read as zero
  assign flags_word = {s.flag_byte, 1'b0, s.clamp, s.mode, 3'h0};

  daf_alu u_alu (
    .op_i(eff_op),
    .mode_i(s.mode),
    .clamp_i(s.clamp),
    .left_i(s.left),
    .right_i(s.right),
    .carry_real_i(s.flag_byte[FB_CARRY_RE]),
    .carry_imag_i(s.flag_byte[FB_CARRY_IM]),
    .res_o(alu_res),
    .sign_re_o(a_sign_re),
    .sign_im_o(a_sign_im),
    .carry_re_o(a_carry_re),
    .carry_im_o(a_carry_im),
    .z_o(a_z),
    .v_o(a_v),
    .hr_o(a_hr)
  );

  always_comb begin
    next_s = s;
    if (s.bvalid && S_AXI_BREADY_I) begin
      next_s.bvalid = 1'b0;
    end
    if (s.rvalid && S_AXI_RREADY_I) begin
      next_s.rvalid = 1'b0;
    end
    if (wr_go) begin
      next_s.bvalid = 1'b1;
      next_s.bresp = (wsel == REG_NONE) ? RESP_DECERR : RESP_OKAY;
      case (wsel)
        REG_CTRL: begin
          if (S_AXI_WSTRB_I[0]) begin
            next_s.mode = S_AXI_WDATA_I[1:0];
            next_s.clamp = S_AXI_WDATA_I[CTRL_CLAMP];
          end
        end
        REG_LEFT: next_s.left = merge(s.left, S_AXI_WDATA_I, S_AXI_WSTRB_I);
        REG_RIGHT: next_s.right = merge(s.right, S_AXI_WDATA_I, S_AXI_WSTRB_I);
        REG_ACCESS: begin
          if (S_AXI_WSTRB_I[0]) begin
            next_s.access_mode = S_AXI_WDATA_I[6:0];
          end
        end
        default: ;
      endcase
    end
    if (tst_wr) begin
      next_s.test = S_AXI_WDATA_I[4:0];
      next_s.taken = S_AXI_WDATA_I[TEST_SENSE] ? tst_cond : !tst_cond;
      if (S_AXI_WDATA_I[3:0] == TST_STICKY) begin
        next_s.flag_byte[FB_STICKY] = 1'b0;
      end
    end
    if (cmd_wr && (func == OP_REPEAT_LOAD || func == OP_REPEAT_EXEC_RELOAD)) begin
      next_s.rpt = S_AXI_WDATA_I[CMD_RPT_LSB +: 5];
    end
    if (cmd_wr && eff_op == OP_LOAD_FLAGS) begin
      next_s.flag_byte = {s.left[15:9], 2'b00};
    end
    if (exec) begin
      next_s.result = alu_res;
      next_s.flag_byte[FB_SIGN_RE] = a_sign_re;
      next_s.flag_byte[FB_SIGN_IM] = a_sign_im;
      next_s.flag_byte[FB_CARRY_RE] = a_carry_re;
      next_s.flag_byte[FB_CARRY_IM] = a_carry_im;
      next_s.flag_byte[FB_ZERO] = a_z;
      next_s.flag_byte[FB_WRAP] = a_v;
      next_s.flag_byte[FB_STICKY] = s.flag_byte[FB_STICKY] | a_v;
      next_s.flag_byte[FB_HALF] = s.flag_byte[FB_HALF] | a_hr;
    end
    // a multiplier event wins over a load-flags clear in the same cycle
    if (MUL_OVF_I) begin
      next_s.flag_byte[FB_PROD] = 1'b1;
    end
    if (rd_go) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = (rsel == REG_NONE) ? RESP_DECERR : RESP_OKAY;
      case (rsel)
        REG_CTRL: next_s.rdata = {29'h0, s.clamp, s.mode};
        REG_LEFT: next_s.rdata = s.left;
        REG_RIGHT: next_s.rdata = s.right;
        REG_RESULT: next_s.rdata = s.result;
        REG_FLAGS: next_s.rdata = {16'h0, flags_word};
        REG_TEST: next_s.rdata = {23'h0, s.taken, 3'h0, s.test};
        REG_REPEAT: next_s.rdata = {27'h0, s.rpt};
        REG_ACCESS: next_s.rdata = {25'h0, s.access_mode};
        default: next_s.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      s <= '0;
      s.mode <= MODE_RESET;
      s.access_mode <= ACCESS_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign S_AXI_BVALID_O = s.bvalid;
  assign S_AXI_BRESP_O = s.bresp;
  assign S_AXI_RVALID_O = s.rvalid;
  assign S_AXI_RDATA_O = s.rdata;
  assign S_AXI_RRESP_O = s.rresp;
  assign FLAGS_O = flags_word;
  assign RESULT_O = s.result;
  assign BRANCH_TAKEN_O = s.taken;

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);

  AST_CONJ_ADD: assert property (
    exec && eff_op == OP_CONJ_ADD && s.mode == MODE_CPLX && !s.clamp |=>
      s.result[31:16] == 16'($past(s.right[31:16]) - $past(s.left[31:16])))
    else $error("conjugate add imaginary part wrong");
  AST_REPEAT_LOAD: assert property (
    cmd_wr && func == OP_REPEAT_EXEC_RELOAD |=> s.rpt == $past(S_AXI_WDATA_I[12:8]))
    else $error("repeat code not reloaded");
  AST_SHIFT_OVF: assert property (
    exec && eff_op == OP_ARITH_LSH && s.mode == MODE_REAL && !s.clamp |=>
      s.flag_byte[FB_WRAP] == (s.result[15] ^ s.result[14]))
    else $error("shift overflow flag wrong");
  AST_SIGN_REAL: assert property (
    exec && s.mode == MODE_REAL && !s.clamp |=> s.flag_byte[FB_SIGN_RE] == s.result[15])
    else $error("real sign flag wrong");
  AST_SIGN_DOUBLE: assert property (
    exec && s.mode == MODE_DOUBLE |=> s.flag_byte[FB_SIGN_RE] == s.result[31])
    else $error("double sign flag wrong");
  AST_SIGN_IMAG: assert property (
    exec && s.mode == MODE_CPLX && !s.clamp |=> s.flag_byte[FB_SIGN_IM] == s.result[31])
    else $error("imaginary sign flag wrong");
  AST_IMAG_QUIET: assert property (
    exec && s.mode != MODE_CPLX |=> !s.flag_byte[FB_SIGN_IM] && !s.flag_byte[FB_CARRY_IM])
    else $error("imaginary flags set outside complex mode");
  AST_ZERO_CPLX: assert property (
    exec && s.mode == MODE_CPLX && !s.clamp |=> s.flag_byte[FB_ZERO] == (s.result == 32'h0))
    else $error("zero flag wrong in complex mode");
  AST_STICKY_SET: assert property (
    exec && a_v |=> s.flag_byte[FB_STICKY] && s.flag_byte[FB_WRAP])
    else $error("sticky overflow not set");
  AST_STICKY_CLR: assert property (
    tst_wr && S_AXI_WDATA_I[3:0] == TST_STICKY ##1 !wr_go [*2] |=> !s.flag_byte[FB_STICKY])
    else $error("sticky overflow not cleared by test");
  AST_HALF_SET: assert property (
    exec && a_hr |=> s.flag_byte[FB_HALF])
    else $error("half-range flag not set");
  AST_HALF_HOLD: assert property (
    s.flag_byte[FB_HALF] && !(cmd_wr && eff_op == OP_LOAD_FLAGS) |=> s.flag_byte[FB_HALF])
    else $error("half-range flag dropped");
  AST_LOAD_CLEAR: assert property (
    cmd_wr && eff_op == OP_LOAD_FLAGS && !MUL_OVF_I |=>
      !s.flag_byte[FB_HALF] && !s.flag_byte[FB_PROD])
    else $error("load-flags did not clear latched flags");
  AST_PRODUCT: assert property (
    MUL_OVF_I |=> s.flag_byte[FB_PROD] ##1 (s.flag_byte[FB_PROD] || $past(cmd_wr)))
    else $error("product overflow not latched");
  AST_CLEAR_OP: assert property (
    exec && eff_op == OP_CLR |=> s.flag_byte[FB_ZERO] && !s.flag_byte[FB_CARRY_RE]
      && !s.flag_byte[FB_WRAP] && s.result == 32'h0)
    else $error("clear op flags wrong");
  AST_BRANCH_ALWAYS: assert property (
    tst_wr && S_AXI_WDATA_I[3:0] == TST_ALWAYS |=>
      BRANCH_TAKEN_O == $past(S_AXI_WDATA_I[TEST_SENSE]))
    else $error("always test code wrong");
  AST_CLAMP: assert property (
    exec && s.clamp && s.mode == MODE_REAL && a_v |=>
      s.result[15:0] == CLAMP_POS || s.result[15:0] == CLAMP_NEG)
    else $error("clamping not applied");
  AST_WRITE_RESP: assert property (
    wr_go |=> S_AXI_BVALID_O)
    else $error("write response missing");
  AST_WRITE_HOLD: assert property (
    S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O))
    else $error("write response dropped early");
  AST_READ_HOLD: assert property (
    S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O))
    else $error("read data dropped early");

  COV_CPLX_ADD: cover property (exec && s.mode == MODE_CPLX && eff_op == OP_ADD);
  COV_REPEAT: cover property (cmd_wr && func == OP_REPEAT_EXEC ##[1:20] tst_wr);
  COV_STICKY_TAKEN: cover property (tst_wr && S_AXI_WDATA_I[3:0] == TST_STICKY && tst_cond);
  COV_CLAMP: cover property (exec && s.clamp && a_v);
endmodule // daf_flag_unit

//--- bench/daf_seq_model.sv
// behavioural sequencer side: condition levels and multiplier overflow pulse
`timescale 1ns/10ps
module daf_seq_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] cond_i,
  input wire logic ovf_req_i,
  output logic [7:0] ext_cond_o,
  output logic mul_ovf_o
);
  logic req_d;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_cond_o <= 8'h00;
      mul_ovf_o <= 1'b0;
      req_d <= 1'b0;
    end else begin
      ext_cond_o <= cond_i;
      // one pulse per request, as a multiplier flags a single product
      mul_ovf_o <= ovf_req_i & ~req_d;
      req_d <= ovf_req_i;
    end
  end
endmodule // daf_seq_model

//--- bench/dsp_alu_flag_logic_tb_top.sv
// register-level bench for the flag logic unit
`timescale 1ns/10ps
module dsp_alu_flag_logic_tb_top;
  import daf_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, cond = 8'h00, ext;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, ovf_req = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, rdata_q, result;
  logic [1:0] bresp, rresp, bresp_q, rresp_q;
  logic awready, wready, bvalid, arready, rvalid, taken, mul_ovf;
  logic [15:0] flags;
  int err_count = 0;
  int comparisons = 0;
  always #2 clk = ~clk;
  daf_seq_model u_seq (.clk_i(clk), .rst_n_i(rst_n), .cond_i(cond), .ovf_req_i(ovf_req),
    .ext_cond_o(ext), .mul_ovf_o(mul_ovf));
  daf_flag_unit DUT (.CLK_I(clk), .RESET_N_I(rst_n), .S_AXI_AWADDR_I(awaddr),
    .S_AXI_AWPROT_I(3'h0), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
    .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wvalid),
    .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
    .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARPROT_I(3'h0),
    .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata),
    .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
    .EXT_COND_I(ext), .MUL_OVF_I(mul_ovf), .FLAGS_O(flags), .RESULT_O(result),
    .BRANCH_TAKEN_O(taken));
  task automatic end_sim;
    $display("comparisons %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // ready is looked at on the falling edge so the taking rising edge is free of races
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(negedge clk); while (awready !== 1'b1 || wready !== 1'b1);
    @(posedge clk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(negedge clk); while (bvalid !== 1'b1);
    bresp_q = bresp;
    @(posedge clk);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge clk); while (arready !== 1'b1);
    @(posedge clk);
    arvalid <= 1'b0;
    do @(negedge clk); while (rvalid !== 1'b1);
    rdata_q = rdata;
    rresp_q = rresp;
    @(posedge clk);
    rready <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk("rdata", rdata_q, e);
  endtask
  task automatic ex(input logic [4:0] op, input logic [4:0] rpt = 5'h0);
    wr(OFS_CMD, {19'h0, rpt, 3'h0, op});
  endtask
  task automatic cf(input logic [8:0] m, input logic [8:0] e);
    chk("flag_byte", {23'h0, flags[15:7] & m}, {23'h0, e});
  endtask
  task automatic ct(input logic [31:0] tst, input logic e);
    wr(OFS_TEST, tst);
    chk("taken", {31'h0, taken}, {31'h0, e});
  endtask
  initial begin
    #20000;
    err_count++;
    end_sim;
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("flags", {16'h0, flags}, 32'h8);
    chk("result", result, 32'h0);
    rc(OFS_CTRL, 32'h1);
    rc(OFS_ACCESS, 32'h0);
    wr(OFS_LEFT, 32'h7fff);
    wr(OFS_RIGHT, 32'h1);
    ex(OP_ADD);
    chk("result", result, 32'h8000);
    cf(9'h1ff, 9'h10e);
    ct(32'h1b, 1'b1);
    cf(9'h004, 9'h000);
    ct(32'h1b, 1'b0);
    ex(OP_CLR);
    cf(9'h1ff, 9'h012);
    // complex lanes: imaginary in the upper half of each operand
    wr(OFS_CTRL, 32'h3);
    wr(OFS_LEFT, 32'h10002);
    wr(OFS_RIGHT, 32'h3fffe);
    ex(OP_CONJ_ADD);
    chk("result", result, 32'h20000);
    cf(9'h1ff, 9'h062);
    wr(OFS_LEFT, 32'h0);
    wr(OFS_RIGHT, 32'h80000000);
    ex(OP_TRA_B);
    chk("result", result, 32'h80000000);
    cf(9'h1ff, 9'h082);
    ex(OP_TRA_A);
    cf(9'h1ff, 9'h012);
    wr(OFS_CTRL, 32'h1);
    wr(OFS_LEFT, 32'h4000);
    ex(OP_ARITH_LSH);
    chk("result", result, 32'h8000);
    cf(9'h148, 9'h108);
    wr(OFS_CTRL, 32'h5);
    wr(OFS_LEFT, 32'h7fff);
    wr(OFS_RIGHT, 32'h1);
    ex(OP_ADD);
    chk("result", result, {16'h0, CLAMP_POS});
    wr(OFS_LEFT, 32'h8000);
    wr(OFS_RIGHT, 32'hffff);
    ex(OP_ADD);
    chk("result", result, {16'h0, CLAMP_NEG});
    wr(OFS_CTRL, 32'h6);
    wr(OFS_LEFT, 32'h7fffffff);
    wr(OFS_RIGHT, 32'h1);
    ex(OP_ADD);
    chk("result", result, 32'h80000000);
    cf(9'h108, 9'h108);
    ovf_req <= 1'b1;
    @(posedge clk);
    ovf_req <= 1'b0;
    repeat (3) @(posedge clk);
    cf(9'h001, 9'h001);
    wr(OFS_LEFT, 32'hfe00);
    ex(OP_LOAD_FLAGS);
    cf(9'h1ff, 9'h1fc);
    wr(OFS_CTRL, 32'h1);
    wr(OFS_LEFT, 32'h3);
    ex(OP_REPEAT_LOAD, OP_ADD);
    rc(OFS_REPEAT, 32'h2);
    ex(OP_REPEAT_EXEC_RELOAD, OP_XOR);
    chk("result", result, 32'h4);
    rc(OFS_REPEAT, 32'hc);
    ex(OP_REPEAT_EXEC);
    chk("result", result, 32'h2);
    // one pass over eight more real-mode codes
    wr(OFS_LEFT, 32'h8001);
    wr(OFS_RIGHT, 32'h3);
    ex(OP_SUB);
    chk("result", result, 32'h7ffe);
    cf(9'h148, 9'h048);
    ex(OP_ROR);
    chk("result", result, 32'hc000);
    ex(OP_ADDS);
    chk("result", result, 32'hf803);
    cf(9'h140, 9'h100);
    ex(OP_AND);
    chk("result", result, 32'h1);
    cf(9'h058, 9'h000);
    ex(OP_LSLB);
    chk("result", result, 32'h100);
    ex(OP_SET);
    chk("result", result, 32'hffff);
    ex(OP_COM_B);
    chk("result", result, 32'hfffc);
    ex(OP_COM_A);
    chk("result", result, 32'h7ffe);
    ct(32'h10, 1'b1);
    ct(32'h00, 1'b0);
    cond <= 8'h01;
    ct(32'h14, 1'b1);
    rc(OFS_TEST, 32'h114);
    ct(32'h04, 1'b0);
    wr(8'h3c, 32'h1);
    chk("bresp", {30'h0, bresp_q}, {30'h0, RESP_DECERR});
    rd(8'h3c);
    chk("rresp", {30'h0, rresp_q}, {30'h0, RESP_DECERR});
    chk("rdata", rdata_q, 32'h0);
    wr(OFS_ACCESS, 32'h7f);
    rc(OFS_ACCESS, 32'h7f);
    end_sim;
  end
endmodule // dsp_alu_flag_logic_tb_top
